// >>> pkg/ncc_pkg.sv
/*
  ncc_pkg: constants and carrier types for the NAND flash command host.
  assumes a 20 MHz ref_clk and an x8 parallel NAND device on the far side.
*/
package ncc_pkg;
  // --------------------------------------------------------------------
  // flash command codes
  // --------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_0    = 8'h00;
  localparam logic [7:0] CMD_RD_CONF   = 8'h30;
  localparam logic [7:0] CMD_COL_MOVE  = 8'h05;
  localparam logic [7:0] CMD_COL_CONF  = 8'he0;
  localparam logic [7:0] CMD_PROG_LOAD = 8'h80;
  localparam logic [7:0] CMD_PROG_CONF = 8'h10;
  localparam logic [7:0] CMD_CACHE_CONF= 8'h15;
  localparam logic [7:0] CMD_ERASE_1   = 8'h60;
  localparam logic [7:0] CMD_ERASE_2   = 8'hd0;
  localparam logic [7:0] CMD_READ_ID   = 8'h90;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_STATUS_PL = 8'h78;
  localparam logic [7:0] CMD_RESET     = 8'hff;
  localparam logic [7:0] CMD_PARAM     = 8'hec;
  localparam logic [7:0] ADDR_ID_PLAIN = 8'h00;
  localparam logic [7:0] ADDR_ID_ONFI  = 8'h20;
  localparam logic [7:0] STATUS_RESET  = 8'he0;
  // --------------------------------------------------------------------
  // status byte fields
  // --------------------------------------------------------------------
  localparam int SR_FAIL      = 0;
  localparam int SR_CACHE_FAIL= 1;
  localparam int SR_CTRL_RDY  = 5;
  localparam int SR_RDY       = 6;
  localparam int SR_WP_OFF    = 7;
  localparam int PAGES_PER_BLK= 64;
  localparam int PAGE_BYTES   = 2160;
  // --------------------------------------------------------------------
  // host register map (word offsets on the local port)
  // --------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0; // w: [3:0] op, go on write
  localparam logic [3:0] REG_ADDR   = 4'h1; // w: address byte
  localparam logic [3:0] REG_NADDR  = 4'h2; // w: number of address cycles
  localparam logic [3:0] REG_WDATA  = 4'h3; // w: data byte to push
  localparam logic [3:0] REG_STAT   = 4'h4; // r: host state
  localparam logic [3:0] REG_RDATA  = 4'h5; // r: last byte read
  localparam logic [3:0] REG_FSTAT  = 4'h6; // r: last flash status byte
  localparam logic [3:0] REG_NREAD  = 4'h7; // w: bytes to read
  localparam int STAT_BUSY = 0;
  localparam int STAT_RB   = 1;
  localparam int STAT_REJ  = 2;
  // timing: one bus phase per enable pulse
  localparam int  CLK_HZ      = 20_000_000;
  localparam int  PHASE_NS    = 50;
  localparam int  PHASE_CYC   = (PHASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // extra phases read_enable_n stays low so read data clears the three pin flops
  localparam int  RD_SYNC_CYC = 4;
  // host operations
  typedef enum logic [3:0] {
    OP_CMD    = 4'h0, // single command byte (reset, confirms, 70h, 00h...)
    OP_ADDR   = 4'h1, // address cycles from REG_ADDR repeated
    OP_WRITE  = 4'h2, // one data byte
    OP_READ   = 4'h3, // REG_NREAD data bytes
    OP_WAIT   = 4'h4  // wait for ready pin
  } ncc_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_STROBE = 3'b010,
    ST_HOLD = 3'b011, ST_WAITRB = 3'b100
  } ncc_state_t;
  // pins toward the flash
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_enable_n;
    logic       wp_n;
    logic [7:0] io_o;
    logic       io_oe;
  } ncc_pins_t;
endpackage

// >>> design/ncc_host.sv
/*
  ncc_host: host controller that drives an x8 NAND flash over its pins.
  software builds each flash sequence from single steps (command byte,
  address cycles, data bytes, wait on ready) through a small register port;
  the flash pins are async to ref_clk, so ready_busy and io inputs are
  synchronised through three flops.
*/
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module ncc_host (
  input  wire logic              ref_clk,      // 20 MHz clock
  input  wire logic              rst_b,        // async reset, active low
  input  wire logic [3:0]        reg_addr,     // register word index
  input  wire logic [7:0]        reg_wdata,    // write data
  input  wire logic              reg_wr,       // write strobe
  input  wire logic              reg_rd,       // read strobe
  output logic      [7:0]        reg_rdata,    // read data, cycle after strobe
  output ncc_pkg::ncc_pins_t     flash_pins,   // pins driven to the flash
  input  wire logic [7:0]        flash_io_i,   // io bus level from the flash
  input  wire logic              ready_busy_pin // ready/busy pin, high = ready
);
  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  ncc_pkg::ncc_state_t state_r;
  ncc_pkg::ncc_op_t    op_r;
  logic [7:0]  addr_byte_r;
  logic [2:0]  naddr_r;
  logic [2:0]  acnt_r;
  logic [7:0]  wdata_r;
  logic [11:0] nread_r;
  logic [11:0] rcnt_r;
  logic [7:0]  rdata_r;
  logic [7:0]  fstat_r;
  logic [7:0]  last_cmd_r;
  logic        rej_r;
  logic [3:0]  ph_cnt_r;
  logic [2:0]  rd_wait_r;
  logic        ph_en;
  logic [2:0]  rb_sync_r;
  logic [7:0]  io_s1_r;
  logic [7:0]  io_s2_r;
  logic [7:0]  io_s3_r;
  logic        rb_ok;
  logic        go;
  logic        busy_only;
  ncc_pkg::ncc_pins_t pins_r;

  // ------------------------------------------------------------------
  // phase divider: one enable pulse per bus phase
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_cnt_r <= 4'h0;
    end else if (ph_cnt_r == 4'(ncc_pkg::PHASE_CYC - 1)) begin
      ph_cnt_r <= 4'h0;
    end else begin
      ph_cnt_r <= ph_cnt_r + 4'h1;
    end
  end
  assign ph_en = (ph_cnt_r == 4'(ncc_pkg::PHASE_CYC - 1));

  // pin synchronisers; ready counts once ready_busy stages two and three are both high
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rb_sync_r <= 3'h0;
      io_s1_r   <= 8'h00;
      io_s2_r   <= 8'h00;
      io_s3_r   <= 8'h00;
    end else begin
      rb_sync_r <= {rb_sync_r[1:0], ready_busy_pin};
      io_s1_r   <= flash_io_i;
      io_s2_r   <= io_s1_r;
      io_s3_r   <= io_s2_r;
    end
  end
  assign rb_ok = rb_sync_r[1] & rb_sync_r[2];

  // ------------------------------------------------------------------
  // software register writes
  // ------------------------------------------------------------------
  assign go = reg_wr && (reg_addr == ncc_pkg::REG_CTRL) && (state_r == ncc_pkg::ST_IDLE);
  // while the flash is busy only status (70h/78h) and reset may be sent;
  // other commands are refused here rather than silently lost in the flash
  assign busy_only = !rb_ok && (reg_wdata[3:0] == 4'(ncc_pkg::OP_CMD))
                     && (wdata_r != ncc_pkg::CMD_STATUS) && (wdata_r != ncc_pkg::CMD_STATUS_PL)
                     && (wdata_r != ncc_pkg::CMD_RESET);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_byte_r <= 8'h00;
      naddr_r     <= 3'h1;
      wdata_r     <= 8'h00;
      nread_r     <= 12'h001;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ncc_pkg::REG_ADDR:  addr_byte_r <= reg_wdata;
        ncc_pkg::REG_NADDR: naddr_r     <= reg_wdata[2:0];
        ncc_pkg::REG_WDATA: wdata_r     <= reg_wdata;
        ncc_pkg::REG_NREAD: nread_r     <= {4'h0, reg_wdata};
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // sequencer: setup once per op except OP_WAIT (straight to ST_WAITRB), then strobe low, strobe high per bus cycle
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ncc_pkg::ST_IDLE;
      op_r    <= ncc_pkg::OP_CMD;
      acnt_r  <= 3'h0;
      rcnt_r  <= 12'h000;
      rej_r   <= 1'b0;
      rd_wait_r <= 3'h0;
    end else if (go) begin
      rej_r <= busy_only;
      rd_wait_r <= 3'h0;
      if (!busy_only) begin
        op_r    <= ncc_pkg::ncc_op_t'(reg_wdata[3:0]);
        acnt_r  <= 3'h0;
        rcnt_r  <= 12'h000;
        state_r <= (reg_wdata[3:0] == 4'(ncc_pkg::OP_WAIT)) ? ncc_pkg::ST_WAITRB : ncc_pkg::ST_SETUP;
      end
    end else if (ph_en) begin
      unique case (state_r)
        ncc_pkg::ST_IDLE:   state_r <= ncc_pkg::ST_IDLE;
        ncc_pkg::ST_SETUP:  state_r <= ncc_pkg::ST_STROBE;
        ncc_pkg::ST_STROBE: begin
          // a read strobe is stretched: the io level needs three flops before it counts
          if (op_r == ncc_pkg::OP_READ && rd_wait_r != 3'(ncc_pkg::RD_SYNC_CYC)) begin
            rd_wait_r <= rd_wait_r + 3'h1;
          end else begin
            rd_wait_r <= 3'h0;
            state_r   <= ncc_pkg::ST_HOLD;
          end
        end
        ncc_pkg::ST_HOLD: begin
          if (op_r == ncc_pkg::OP_ADDR && (acnt_r + 3'h1) < naddr_r) begin
            acnt_r  <= acnt_r + 3'h1;
            state_r <= ncc_pkg::ST_STROBE;
          end else if (op_r == ncc_pkg::OP_READ && (rcnt_r + 12'h001) < nread_r) begin
            rcnt_r  <= rcnt_r + 12'h001;
            state_r <= ncc_pkg::ST_STROBE;
          end else begin
            state_r <= ncc_pkg::ST_IDLE;
          end
        end
        ncc_pkg::ST_WAITRB: if (rb_ok) state_r <= ncc_pkg::ST_IDLE;
        default: state_r <= ncc_pkg::ST_IDLE;
      endcase
    end
  end

  // last command byte issued; a status command keeps later reads as status
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_cmd_r <= ncc_pkg::CMD_RESET;
    end else if (go && !busy_only && reg_wdata[3:0] == 4'(ncc_pkg::OP_CMD)) begin
      last_cmd_r <= wdata_r;
    end
  end

  // sample read data on the last low phase of read_enable_n, once through the sync flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
      fstat_r <= ncc_pkg::STATUS_RESET;
    end else if (ph_en && state_r == ncc_pkg::ST_STROBE && op_r == ncc_pkg::OP_READ
                 && rd_wait_r == 3'(ncc_pkg::RD_SYNC_CYC)) begin
      rdata_r <= io_s3_r;
      if (last_cmd_r == ncc_pkg::CMD_STATUS || last_cmd_r == ncc_pkg::CMD_STATUS_PL) begin
        fstat_r <= io_s3_r;
      end
    end
  end

  // ------------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pins_r <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_enable_n: 1'b1,
                  wp_n: 1'b1, io_o: 8'h00, io_oe: 1'b0};
    end else begin
      pins_r.ce_n          <= (state_r == ncc_pkg::ST_IDLE) || (state_r == ncc_pkg::ST_WAITRB);
      pins_r.cle           <= (state_r != ncc_pkg::ST_IDLE) && op_r == ncc_pkg::OP_CMD;
      pins_r.ale           <= (state_r != ncc_pkg::ST_IDLE) && op_r == ncc_pkg::OP_ADDR;
      pins_r.we_n          <= !(state_r == ncc_pkg::ST_STROBE && op_r != ncc_pkg::OP_READ
                                && op_r != ncc_pkg::OP_WAIT);
      pins_r.read_enable_n <= !(state_r == ncc_pkg::ST_STROBE && op_r == ncc_pkg::OP_READ);
      pins_r.wp_n          <= 1'b1; // unprotected, status resets to e0h
      // command byte carries 15h/10h/90h/ech etc. as software chose
      pins_r.io_o          <= (op_r == ncc_pkg::OP_ADDR) ? addr_byte_r : wdata_r;
      pins_r.io_oe         <= (state_r != ncc_pkg::ST_IDLE) && (state_r != ncc_pkg::ST_WAITRB)
                              && op_r != ncc_pkg::OP_READ;
    end
  end
  assign flash_pins = pins_r;

  // ------------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ncc_pkg::REG_STAT:  reg_rdata <= {5'h00, rej_r, rb_ok, state_r != ncc_pkg::ST_IDLE};
        ncc_pkg::REG_RDATA: reg_rdata <= rdata_r;
        ncc_pkg::REG_FSTAT: reg_rdata <= fstat_r;
        default:            reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence strobe_seq;
    state_r == ncc_pkg::ST_STROBE;
  endsequence
  strobes_excl_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(!pins_r.we_n && !pins_r.read_enable_n)) else $error("we and re low together");
  busy_refuse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    go && busy_only |=> rej_r && state_r == ncc_pkg::ST_IDLE) else $error("busy command not refused");
  we_follows_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    strobe_seq and op_r == ncc_pkg::OP_CMD |=> !pins_r.we_n && pins_r.cle) else $error("we not strobed");
  wait_ends_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == ncc_pkg::ST_WAITRB && rb_ok && ph_en |=> state_r == ncc_pkg::ST_IDLE) else $error("wait stuck");
  status_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ph_en && state_r == ncc_pkg::ST_STROBE && op_r == ncc_pkg::OP_READ
    && rd_wait_r == 3'(ncc_pkg::RD_SYNC_CYC) && last_cmd_r == ncc_pkg::CMD_STATUS
    |=> fstat_r == $past(io_s3_r)) else $error("status not captured");
  oe_off_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !pins_r.read_enable_n |-> !pins_r.io_oe) else $error("bus contention on read");
  ce_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == ncc_pkg::ST_IDLE ##1 state_r == ncc_pkg::ST_IDLE |-> pins_r.ce_n) else $error("ce low idle");
  wp_high_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pins_r.wp_n) else $error("wp dropped");
endmodule // ncc_host

// >>> verif/ncc_flash_model.sv
/*
  ncc_flash_model: behavioural x8 NAND device behind the ncc_host pins.
  assumes registered host pins; commands latch on the rising write strobe.
*/
`timescale 1ns/1ps
module ncc_flash_model #(
  parameter int         BUSY_NS  = 2000,  // array program or erase time
  parameter int         CACHE_NS = 500,   // cache release time after 15h
  parameter int         RST_NS   = 500,   // reset stage length
  parameter int         HOLD_NS  = 100,   // data hold after read strobe rises
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_ID   = 8'h3c  // arbitrary value
) (
  input  wire ncc_pkg::ncc_pins_t pins,   // pins from the host
  output logic [7:0]              io_bus, // resolved io bus
  output logic                    rb      // ready/busy, high = ready
);
  realtime    rdy_t = 0, arr_t = 0, rst_t = 0;
  logic [7:0] dout = 8'h00;
  logic [7:0] tbl [6];
  logic       d_oe = 1'b0;
  int         mode = 0, pmode = 0, idx = 0, seq = 0;
  // released bus shows the inverse so stale data never looks valid
  assign io_bus = pins.io_oe ? pins.io_o : (d_oe ? dout : ~dout);
  // pin follows cache readiness
  always begin
    rb = ($realtime >= rdy_t);
    #5;
  end
  // fail bits always pass, wp_n high
  function automatic logic [7:0] stat();
    return {1'b1, $realtime >= rdy_t, $realtime >= arr_t, 5'h00};
  endfunction
  // -------------------------------------------------------------------
  // command and address latch
  // -------------------------------------------------------------------
  always @(posedge pins.we_n) if (!pins.ce_n) begin
    if (pins.cle && (rb || pins.io_o == 8'h70 || pins.io_o == 8'h78 || pins.io_o == 8'hff)) begin
      case (pins.io_o)
        8'h70, 8'h78: begin pmode = mode; mode = 1; end
        8'h00: mode = (pmode == 4) ? 4 : 0;
        8'hff: if ($realtime >= rst_t) begin
          mode = 0; rst_t = $realtime + RST_NS; rdy_t = rst_t; arr_t = rst_t;
        end
        8'h90: begin mode = 2; idx = 0; tbl = '{MAKER_ID, DEV_ID, 8'h90, 8'h95, 8'h07, 8'h00}; end
        8'hec: begin mode = 4; idx = 0; tbl = '{8'h4f, 8'h4e, 8'h46, 8'h49, 8'h02, 8'h00}; end
        8'h15: begin rdy_t = $realtime + CACHE_NS; arr_t = $realtime + BUSY_NS; end
        8'h10, 8'hd0: begin
          arr_t = (arr_t > $realtime ? arr_t : $realtime) + BUSY_NS; rdy_t = arr_t;
        end
        default: ;
      endcase
    end else if (pins.ale && mode == 2 && pins.io_o == 8'h20)
      tbl = '{8'h4f, 8'h4e, 8'h46, 8'h49, 8'h00, 8'h00};
  end
  // output on read strobe fall
  always @(negedge pins.read_enable_n) if (!pins.ce_n) begin
    seq++;
    d_oe = 1'b1;
    if (mode == 1) dout = stat();
    else begin dout = tbl[idx]; idx = (idx + 1) % 6; end
  end
  // hold time runs out unless a new strobe came
  always @(posedge pins.read_enable_n) begin : rel
    int k;
    k = seq;
    #(HOLD_NS);
    if (k == seq) d_oe = 1'b0;
  end
endmodule // ncc_flash_model

// >>> verif/tb.sv
/*
  tb: self-checking bench for ncc_host against ncc_flash_model.
  assumes the register map and op codes of ncc_pkg.
*/
`timescale 1ns/1ps
module tb;
  logic               ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rb;
  logic [3:0]         reg_addr = 4'h0;
  logic [7:0]         reg_wdata = 8'h00, reg_rdata, io_bus, d;
  ncc_pkg::ncc_pins_t pins;
  int                 num_errors = 0, n_tests = 0, cyc = 0;
  always #25 ref_clk = ~ref_clk;
  ncc_host u_ncc_host (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_pins(pins), .flash_io_i(io_bus),
    .ready_busy_pin(rb));
  ncc_flash_model #(.MAKER_ID(8'h5a), .DEV_ID(8'h3c)) u_ncc_flash_model (.pins(pins), .io_bus(io_bus), .rb(rb));
  // -------------------------------------------------------------------
  // port tasks
  // -------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge ref_clk); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk); reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // launch an op and poll busy under a bound
  task automatic op(input logic [3:0] o);
    int i;
    wr(ncc_pkg::REG_CTRL, {4'h0, o});
    @(posedge ref_clk);
    for (i = 0; i < 300; i++) begin rd(ncc_pkg::REG_STAT); if (d[ncc_pkg::STAT_BUSY] === 1'b0) break; end
    chk({7'h00, d[ncc_pkg::STAT_BUSY]}, 8'h00);
  endtask
  task automatic cmd(input logic [7:0] c); wr(ncc_pkg::REG_WDATA, c); op(4'h0); endtask
  task automatic adr(input logic [7:0] a, input logic [7:0] n);
    wr(ncc_pkg::REG_ADDR, a); wr(ncc_pkg::REG_NADDR, n); op(4'h1);
  endtask
  task automatic get(input logic [7:0] exp);
    wr(ncc_pkg::REG_NREAD, 8'h01); op(4'h3); rd(ncc_pkg::REG_RDATA); chk(d, exp);
  endtask
  task automatic prog(input logic [7:0] conf);
    cmd(8'h80); adr($urandom, 8'h05);
    repeat (4) begin wr(ncc_pkg::REG_WDATA, $urandom); op(4'h2); end
    cmd(conf); op(4'h4); cmd(8'h70);
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, well above the expected several hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin num_errors++; $display("[FAIL] %0t timeout", $time); wrap_up(); end
  end
  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  initial begin
    logic [7:0] id [5];
    logic [7:0] sg [4];
    id = '{8'h5a, 8'h3c, 8'h90, 8'h95, 8'h07};
    sg = '{8'h4f, 8'h4e, 8'h46, 8'h49};
    void'($urandom(82294));
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(ncc_pkg::REG_FSTAT); chk(d, 8'he0);
    rd(4'hf); chk(d, 8'h00);
    cmd(8'h70); get(8'he0); get(8'he0);
    rd(ncc_pkg::REG_FSTAT); chk(d, 8'he0);
    cmd(8'h90); adr(8'h00, 8'h01);
    foreach (id[i]) get(id[i]);
    cmd(8'h90); adr(8'h20, 8'h01);
    foreach (sg[i]) get(sg[i]);
    // id request during erase must be held back
    cmd(8'h60); adr($urandom, 8'h03); cmd(8'hd0); cmd(8'h90);
    rd(ncc_pkg::REG_STAT); chk(d & 8'h04, 8'h04);
    cmd(8'h70); get(8'h80);
    op(4'h4); get(8'he0);
    // cache page: cache free while array still busy
    prog(8'h15); get(8'hc0);
    prog(8'h10); get(8'he0);
    // double reset over a running erase
    cmd(8'h60); adr($urandom, 8'h03); cmd(8'hd0); cmd(8'hff); cmd(8'hff);
    op(4'h4); cmd(8'h70); get(8'he0);
    rd(ncc_pkg::REG_FSTAT); chk(d, 8'he0);
    cmd(8'hec); adr(8'h00, 8'h01); get(sg[0]); get(sg[1]);
    cmd(8'h70); get(8'he0); cmd(8'h00); get(sg[2]); get(sg[3]);
    wrap_up();
  end
endmodule // tb
